// ==== include/cpu_status_pkg.sv ====
// Constants and types shared by the CPU status and address generation block
package cpu_status_pkg;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 16;
  localparam int ACC_W      = 40;
  localparam int PC_W       = 23;
  localparam int LSTART_W   = 24;
  localparam int NUM_CTX    = 5;
  localparam int NUM_ACC_SETS = 3;
  localparam int FILE_W     = 13;

  // ----------------------------------------
  // Memory-mapped byte offsets
  // ----------------------------------------
  localparam logic [15:0] OFS_W0       = 16'h0000;
  localparam logic [15:0] OFS_W15      = 16'h001E;
  localparam logic [15:0] OFS_ACCUMULATOR_FIRST_L   = 16'h0020;
  localparam logic [15:0] OFS_ACCUMULATOR_FIRST_H   = 16'h0022;
  localparam logic [15:0] OFS_ACCUMULATOR_FIRST_U   = 16'h0024;
  localparam logic [15:0] OFS_ACCUMULATOR_SECOND_L   = 16'h0026;
  localparam logic [15:0] OFS_ACCUMULATOR_SECOND_H   = 16'h0028;
  localparam logic [15:0] OFS_ACCUMULATOR_SECOND_U   = 16'h002A;
  localparam logic [15:0] OFS_PC_L     = 16'h002C;
  localparam logic [15:0] OFS_PC_H     = 16'h002E;
  localparam logic [15:0] OFS_LSTART_L = 16'h0030;
  localparam logic [15:0] OFS_LSTART_H = 16'h0032;
  localparam logic [15:0] OFS_STATUS   = 16'h0034;

  // ----------------------------------------
  // Status field positions and reset
  // ----------------------------------------
  localparam int BIT_C       = 0;
  localparam int BIT_Z       = 1;
  localparam int BIT_OV      = 2;
  localparam int BIT_N       = 3;
  localparam int BIT_RA      = 4;
  localparam int IPL_LSB     = 5;
  localparam int IPL_W       = 3;
  localparam int BIT_SAB     = 13;
  localparam int BIT_SB      = 14;
  localparam int BIT_SA      = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [2:0]  IPL_BLOCK    = 3'h7;

  // ----------------------------------------
  // Operand addressing modes
  // ----------------------------------------
  typedef enum logic [7:0] {
    EA_FILE   = 8'h01,
    EA_REG    = 8'h02,
    EA_IND    = 8'h04,
    EA_POST   = 8'h08,
    EA_PRE    = 8'h10,
    EA_INDEX  = 8'h20,
    EA_LITOFF = 8'h40,
    EA_LIT    = 8'h80
  } ea_mode_t;

endpackage

// ==== rtl/cpu_status_and_address_gen.sv ====
// CPU status flags, programmer's model registers and operand address generation
//
// Functional notes
// - Priority field in status bits 7-5; value 111 blocks user interrupts.
// - Core-control high bit above field forms level; set blocks user interrupts.
// - Priority field cannot be written while nesting disable is set.
// - Status bit 4 shows a single-instruction repeat loop running.
// - Negative flag, bit 3, follows result sign.
// - Overflow flag, bit 2, marks two's-complement sign overflow.
// - Zero flag, bit 1, is sticky; a non-zero result clears it.
// - Carry flag, bit 0, holds carry out of the top result bit.
// - Status writes change both saturation flags, directly or by clearing combined bit.
// - File operands use 13-bit addresses; only move reaches full space.
// - File operations use W0 as default operand and result register.
// - Three-operand first operand is a register; second register or 5-bit literal.
// - Register, indirect, post, pre-modified and 5/10-bit literal modes supported.
// - Indirect mode uses pointer contents unchanged as address.
// - Post-modified: access at pointer, then pointer changes by constant.
// - Pre-modified: pointer plus signed constant, then used as address.
// - Indexed: address is pointer plus base register.
// - Literal offset: address is pointer plus literal.
// - File direct: address comes from instruction word only.
// - Sixteen registers plus four alternate sets; mapped W0-W14 follow context.
// - Two 40-bit accumulators with two alternates, 23-bit program counter.
// - All model registers mapped and writable except read-only loop start.
`timescale 1ns/1ps
module cpu_status_and_address_gen (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic [2:0]                 ctx_sel,
  input  wire logic [1:0]                 acc_ctx_sel,
  input  wire logic [15:0]                mm_addr,
  input  wire logic                       mm_wr,
  input  wire logic                       mm_rd,
  input  wire logic [15:0]                mm_wdata,
  output logic      [15:0]                mm_rdata,
  input  wire logic                       alu_valid,
  input  wire logic [15:0]                alu_op_a,
  input  wire logic [15:0]                alu_op_b,
  input  wire logic                       alu_subtract,
  input  wire logic                       alu_use_carry,
  input  wire logic                       upd_c,
  input  wire logic                       upd_z,
  input  wire logic                       upd_ov,
  input  wire logic                       upd_n,
  input  wire logic                       zero_sticky,
  input  wire logic                       wb_to_w,
  input  wire logic                       wb_default,
  input  wire logic [3:0]                 wb_sel,
  output logic      [15:0]                alu_result,
  input  wire logic                       ea_valid,
  input  wire cpu_status_pkg::ea_mode_t   ea_mode,
  input  wire logic [3:0]                 ptr_sel,
  input  wire logic [3:0]                 base_sel,
  input  wire logic [15:0]                mod_amount,
  input  wire logic [9:0]                 literal,
  input  wire logic                       lit_wide,
  input  wire logic [12:0]                file_addr,
  input  wire logic                       file_move,
  input  wire logic [15:0]                move_addr,
  output logic      [15:0]                effective_address,
  output logic      [15:0]                operand_first,
  output logic      [15:0]                operand_second,
  output logic                            operand_in_mem,
  output logic                            ea_strobe,
  input  wire logic                       repeat_running,
  input  wire logic                       nesting_disable,
  input  wire logic                       core_priority_high,
  input  wire logic                       sat_a_event,
  input  wire logic                       sat_b_event,
  input  wire logic                       acc_wr,
  input  wire logic                       acc_wsel,
  input  wire logic [39:0]                acc_wdata,
  input  wire logic                       pc_load,
  input  wire logic [22:0]                pc_value,
  input  wire logic                       lstart_load,
  input  wire logic [23:0]                lstart_value,
  output logic      [15:0]                cpu_status_flags,
  output logic      [3:0]                 processor_priority_level,
  output logic                            user_irq_blocked,
  output logic      [39:0]                accumulator_first,
  output logic      [39:0]                accumulator_second,
  output logic      [22:0]                program_counter
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [4:0][14:0][15:0] default_working_reg;
    logic [15:0]            w15;
    logic [2:0][1:0][39:0]  acc;
    logic [22:0]            pc;
    logic [23:0]            lstart;
    logic [15:0]            sr;
    logic [15:0]            rdata;
    logic [15:0]            alu_res;
    logic [15:0]            ea;
    logic [15:0]            op1;
    logic [15:0]            op2;
    logic                   op_mem;
    logic                   ea_stb;
    logic                   irq_blk;
    logic [3:0]             prio;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] get_w(state_t st, logic [2:0] c, logic [3:0] i);
    return (i == 4'hF) ? st.w15 : st.default_working_reg[c][i];
  endfunction

  function automatic state_t set_w(state_t st, logic [2:0] c, logic [3:0] i, logic [15:0] v);
    state_t r;
    r = st;
    if (i == 4'hF) begin
      r.w15 = v;
    end else begin
      r.default_working_reg[c][i] = v;
    end
    return r;
  endfunction

  function automatic logic [15:0] read_word(state_t st, logic [2:0] c, logic [1:0] a, logic [15:0] ad);
    logic [15:0] v;
    v = 16'h0000;
    if (ad <= cpu_status_pkg::OFS_W15 && !ad[0]) begin
      v = get_w(st, c, ad[4:1]);
    end else begin
      case (ad)
        cpu_status_pkg::OFS_ACCUMULATOR_FIRST_L:   v = st.acc[a][0][15:0];
        cpu_status_pkg::OFS_ACCUMULATOR_FIRST_H:   v = st.acc[a][0][31:16];
        cpu_status_pkg::OFS_ACCUMULATOR_FIRST_U:   v = {8'h00, st.acc[a][0][39:32]};
        cpu_status_pkg::OFS_ACCUMULATOR_SECOND_L:   v = st.acc[a][1][15:0];
        cpu_status_pkg::OFS_ACCUMULATOR_SECOND_H:   v = st.acc[a][1][31:16];
        cpu_status_pkg::OFS_ACCUMULATOR_SECOND_U:   v = {8'h00, st.acc[a][1][39:32]};
        cpu_status_pkg::OFS_PC_L:     v = st.pc[15:0];
        cpu_status_pkg::OFS_PC_H:     v = {9'h000, st.pc[22:16]};
        cpu_status_pkg::OFS_LSTART_L: v = st.lstart[15:0];
        cpu_status_pkg::OFS_LSTART_H: v = {8'h00, st.lstart[23:16]};
        cpu_status_pkg::OFS_STATUS:   v = st.sr;
        default:                      v = 16'h0000;
      endcase
    end
    return v;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic [2:0]  ctx;
  logic [1:0]  actx;
  logic [15:0] b_eff;
  logic [16:0] sum;
  logic [15:0] ptr;
  logic [15:0] base;
  logic [15:0] lit_val;

  always_comb begin
    next_s = s;
    next_s.ea_stb = 1'b0;
    // Out-of-range selects fall back to the primary set
    ctx  = (ctx_sel > 3'h4) ? 3'h0 : ctx_sel;
    actx = (acc_ctx_sel > 2'h2) ? 2'h0 : acc_ctx_sel;
    b_eff = alu_subtract ? ~alu_op_b : alu_op_b;
    sum = {1'b0, alu_op_a} + {1'b0, b_eff} + {16'h0000, (alu_use_carry ? s.sr[cpu_status_pkg::BIT_C] : alu_subtract)};
    ptr  = get_w(s, ctx, ptr_sel);
    base = get_w(s, ctx, base_sel);
    lit_val = lit_wide ? {6'h00, literal} : {11'h000, literal[4:0]};

    if (mm_rd) begin
      next_s.rdata = read_word(s, ctx, actx, mm_addr);
    end

    // ----------------------------------------
    // Mapped writes
    // ----------------------------------------
    if (mm_wr) begin
      if (mm_addr <= cpu_status_pkg::OFS_W15 && !mm_addr[0]) begin
        next_s = set_w(next_s, ctx, mm_addr[4:1], mm_wdata);
      end else begin
        // loop start has no write path
        case (mm_addr)
          cpu_status_pkg::OFS_ACCUMULATOR_FIRST_L: next_s.acc[actx][0][15:0]  = mm_wdata;
          cpu_status_pkg::OFS_ACCUMULATOR_FIRST_H: next_s.acc[actx][0][31:16] = mm_wdata;
          cpu_status_pkg::OFS_ACCUMULATOR_FIRST_U: next_s.acc[actx][0][39:32] = mm_wdata[7:0];
          cpu_status_pkg::OFS_ACCUMULATOR_SECOND_L: next_s.acc[actx][1][15:0]  = mm_wdata;
          cpu_status_pkg::OFS_ACCUMULATOR_SECOND_H: next_s.acc[actx][1][31:16] = mm_wdata;
          cpu_status_pkg::OFS_ACCUMULATOR_SECOND_U: next_s.acc[actx][1][39:32] = mm_wdata[7:0];
          cpu_status_pkg::OFS_PC_L:   next_s.pc[15:0]  = mm_wdata;
          cpu_status_pkg::OFS_PC_H:   next_s.pc[22:16] = mm_wdata[6:0];
          cpu_status_pkg::OFS_STATUS: begin
            next_s.sr[3:0] = mm_wdata[3:0];
            if (!nesting_disable) begin
              next_s.sr[7:5] = mm_wdata[7:5];
            end
            next_s.sr[cpu_status_pkg::BIT_SA] = mm_wdata[cpu_status_pkg::BIT_SA] & mm_wdata[cpu_status_pkg::BIT_SAB];
            next_s.sr[cpu_status_pkg::BIT_SB] = mm_wdata[cpu_status_pkg::BIT_SB] & mm_wdata[cpu_status_pkg::BIT_SAB];
          end
          default: next_s.sr = next_s.sr;
        endcase
      end
    end

    // ----------------------------------------
    // Hardware updates
    // ----------------------------------------
    // accumulator, counter and loop storage
    if (acc_wr) begin
      next_s.acc[actx][acc_wsel] = acc_wdata;
    end
    if (pc_load) begin
      next_s.pc = pc_value;
    end
    if (lstart_load) begin
      next_s.lstart = lstart_value;
    end
    // saturation events win over a write
    if (sat_a_event) begin
      next_s.sr[cpu_status_pkg::BIT_SA] = 1'b1;
    end
    if (sat_b_event) begin
      next_s.sr[cpu_status_pkg::BIT_SB] = 1'b1;
    end
    next_s.sr[cpu_status_pkg::BIT_SAB] = next_s.sr[cpu_status_pkg::BIT_SA] | next_s.sr[cpu_status_pkg::BIT_SB];
    next_s.sr[cpu_status_pkg::BIT_RA] = repeat_running;

    // ----------------------------------------
    // Flags and result write-back
    // ----------------------------------------
    if (alu_valid) begin
      next_s.alu_res = sum[15:0];
      if (upd_n) begin
        next_s.sr[cpu_status_pkg::BIT_N] = sum[15];
      end
      if (upd_ov) begin
        next_s.sr[cpu_status_pkg::BIT_OV] = (alu_op_a[15] == b_eff[15]) && (sum[15] != alu_op_a[15]);
      end
      if (upd_z) begin
        if (sum[15:0] != 16'h0000) begin
          next_s.sr[cpu_status_pkg::BIT_Z] = 1'b0;
        end else if (!zero_sticky) begin
          next_s.sr[cpu_status_pkg::BIT_Z] = 1'b1;
        end
      end
      if (upd_c) begin
        next_s.sr[cpu_status_pkg::BIT_C] = sum[16];
      end
      if (wb_to_w) begin
        next_s = set_w(next_s, ctx, wb_default ? 4'h0 : wb_sel, sum[15:0]);
      end
    end

    // ----------------------------------------
    // Operand addressing
    // ----------------------------------------
    if (ea_valid) begin
      next_s.ea_stb = 1'b1;
      next_s.op1 = base;
      next_s.op2 = 16'h0000;
      next_s.op_mem = 1'b1;
      case (ea_mode)
        cpu_status_pkg::EA_FILE: begin
          next_s.ea = file_move ? move_addr : {3'h0, file_addr};
          next_s.op2 = get_w(s, ctx, 4'h0);
        end
        cpu_status_pkg::EA_REG: begin
          next_s.op_mem = 1'b0;
          next_s.op2 = ptr;
        end
        cpu_status_pkg::EA_IND: begin
          next_s.ea = ptr;
        end
        cpu_status_pkg::EA_POST: begin
          next_s.ea = ptr;
          next_s = set_w(next_s, ctx, ptr_sel, ptr + mod_amount);
        end
        cpu_status_pkg::EA_PRE: begin
          next_s.ea = ptr + mod_amount;
          next_s = set_w(next_s, ctx, ptr_sel, ptr + mod_amount);
        end
        cpu_status_pkg::EA_INDEX: begin
          next_s.ea = ptr + base;
        end
        cpu_status_pkg::EA_LITOFF: begin
          next_s.ea = ptr + {{6{literal[9]}}, literal};
        end
        cpu_status_pkg::EA_LIT: begin
          next_s.op_mem = 1'b0;
          next_s.op2 = lit_val;
        end
        default: next_s.op_mem = 1'b0;
      endcase
    end

    // ----------------------------------------
    // Priority level
    // ----------------------------------------
    // high bit above field
    next_s.prio = {core_priority_high, next_s.sr[7:5]};
    next_s.irq_blk = core_priority_high || (next_s.sr[7:5] == cpu_status_pkg::IPL_BLOCK);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.sr <= cpu_status_pkg::STATUS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign mm_rdata                 = s.rdata;
  assign alu_result               = s.alu_res;
  assign effective_address        = s.ea;
  assign operand_first            = s.op1;
  assign operand_second           = s.op2;
  assign operand_in_mem           = s.op_mem;
  assign ea_strobe                = s.ea_stb;
  assign cpu_status_flags         = s.sr;
  assign processor_priority_level = s.prio;
  assign user_irq_blocked         = s.irq_blk;
  assign accumulator_first        = s.acc[0][0];
  assign accumulator_second       = s.acc[0][1];
  assign program_counter          = s.pc;

endmodule

// ==== verif/cpu_status_and_address_gen_sva.sv ====
// Property checker for the status flags and address generation block
`timescale 1ns/1ps
module cpu_status_and_address_gen_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        mm_wr,
  input wire logic        mm_rd,
  input wire logic [15:0] mm_rdata,
  input wire logic        alu_valid,
  input wire logic [15:0] alu_op_a,
  input wire logic [15:0] alu_op_b,
  input wire logic        alu_subtract,
  input wire logic        alu_use_carry,
  input wire logic        upd_c,
  input wire logic        upd_z,
  input wire logic        upd_n,
  input wire logic        zero_sticky,
  input wire logic [15:0] alu_result,
  input wire logic        ea_valid,
  input wire logic        ea_strobe,
  input wire logic        repeat_running,
  input wire logic        nesting_disable,
  input wire logic        core_priority_high,
  input wire logic [15:0] cpu_status_flags,
  input wire logic [3:0]  processor_priority_level,
  input wire logic        user_irq_blocked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Priority, status, strobe and read data relations
  // ----------------------------------------
  a_level_form: assert property (
    !$past(rst) |-> processor_priority_level == {$past(core_priority_high), cpu_status_flags[7:5]})
    else $error("priority level wrong");
  a_irq_block: assert property (
    !$past(rst) |-> user_irq_blocked == ($past(core_priority_high) || cpu_status_flags[7:5] == 3'h7))
    else $error("interrupt block wrong");
  a_nest_lock: assert property (
    !$past(rst) && $past(nesting_disable) |-> $stable(cpu_status_flags[7:5]))
    else $error("priority changed while locked");
  a_repeat_bit: assert property (
    !$past(rst) |-> cpu_status_flags[4] == $past(repeat_running))
    else $error("repeat bit wrong");
  a_neg_flag: assert property (
    !$past(rst) && $past(alu_valid && upd_n) |-> cpu_status_flags[3] == alu_result[15])
    else $error("negative flag wrong");
  a_zero_flag: assert property (
    !$past(rst) && $past(alu_valid && upd_z) |-> cpu_status_flags[1] ==
      (alu_result == 16'h0000 && (!$past(zero_sticky) || $past(cpu_status_flags[1]))))
    else $error("zero flag wrong");
  a_carry_out: assert property (
    !$past(rst) && $past(alu_valid && upd_c && !alu_use_carry && !alu_subtract) |->
      cpu_status_flags[0] == (({1'b0, $past(alu_op_a)} + {1'b0, $past(alu_op_b)}) > 17'h0FFFF))
    else $error("carry flag wrong");
  a_flags_hold: assert property (
    !$past(rst) && !$past(alu_valid) && !$past(mm_wr) |-> $stable(cpu_status_flags[3:0]))
    else $error("flags changed without cause");
  a_sat_combined: assert property (
    cpu_status_flags[13] == (cpu_status_flags[15] || cpu_status_flags[14]))
    else $error("combined saturation wrong");
  a_strobe_once: assert property (
    !$past(rst) |-> ea_strobe == $past(ea_valid))
    else $error("address strobe wrong");
  a_rdata_hold: assert property (
    !$past(rst) && !$past(mm_rd) |-> $stable(mm_rdata))
    else $error("read data changed");
endmodule

bind cpu_status_and_address_gen cpu_status_and_address_gen_sva i_sva (.ref_clk, .rst, .mm_wr, .mm_rd,
  .mm_rdata, .alu_valid, .alu_op_a, .alu_op_b, .alu_subtract, .alu_use_carry, .upd_c, .upd_z, .upd_n,
  .zero_sticky, .alu_result, .ea_valid, .ea_strobe, .repeat_running, .nesting_disable, .core_priority_high,
  .cpu_status_flags, .processor_priority_level, .user_irq_blocked);

// ==== verif/cpu_status_and_address_gen_test.sv ====
// Self-checking bench for status flags, mapped registers and address generation
`timescale 1ns/1ps
module cpu_status_and_address_gen_test;
  logic        ref_clk = 0, rst = 1, mm_wr = 0, mm_rd = 0, alu_valid = 0, ea_valid = 0, alu_subtract = 0;
  logic        alu_use_carry = 0, upd_c = 0, upd_z = 0, upd_ov = 0, upd_n = 0, zero_sticky = 0, wb_to_w = 0;
  logic        wb_default = 0, lit_wide = 0, file_move = 0, repeat_running = 0, nesting_disable = 0;
  logic        core_priority_high = 0, sat_a_event = 0, sat_b_event = 0, acc_wr = 0, acc_wsel = 0;
  logic        pc_load = 0, lstart_load = 0, operand_in_mem, ea_strobe, user_irq_blocked, rs, as;
  logic [1:0]  acc_ctx_sel = 0;
  logic [2:0]  ctx_sel = 0;
  logic [3:0]  wb_sel = 0, ptr_sel = 4'h2, base_sel = 4'h5, fl = 0, processor_priority_level;
  logic [9:0]  literal = 0;
  logic [12:0] file_addr = 0;
  logic [15:0] mm_addr = 0, mm_wdata = 0, alu_op_a = 0, alu_op_b = 0, mod_amount = 0, move_addr = 0;
  logic [15:0] mm_rdata, alu_result, effective_address, operand_first, operand_second, cpu_status_flags;
  logic [15:0] wm [16];
  logic [15:0] rd_q [$];
  logic [15:0] alu_q [$];
  logic [48:0] ea_q [$];
  logic [48:0] e;
  logic [22:0] pc_value = 0, program_counter;
  logic [23:0] lstart_value = 0;
  logic [39:0] acc_wdata = 0, accumulator_first, accumulator_second;
  cpu_status_pkg::ea_mode_t ea_mode = cpu_status_pkg::EA_FILE;
  int          num_errors = 0, total_checks = 0;

  cpu_status_and_address_gen i_cpu_status_and_address_gen (.ref_clk, .rst, .ctx_sel, .acc_ctx_sel, .mm_addr,
    .mm_wr, .mm_rd, .mm_wdata, .mm_rdata, .alu_valid, .alu_op_a, .alu_op_b, .alu_subtract, .alu_use_carry,
    .upd_c, .upd_z, .upd_ov, .upd_n, .zero_sticky, .wb_to_w, .wb_default, .wb_sel, .alu_result, .ea_valid,
    .ea_mode, .ptr_sel, .base_sel, .mod_amount, .literal, .lit_wide, .file_addr, .file_move, .move_addr,
    .effective_address, .operand_first, .operand_second, .operand_in_mem, .ea_strobe, .repeat_running,
    .nesting_disable, .core_priority_high, .sat_a_event, .sat_b_event, .acc_wr, .acc_wsel, .acc_wdata,
    .pc_load, .pc_value, .lstart_load, .lstart_value, .cpu_status_flags, .processor_priority_level,
    .user_irq_blocked, .accumulator_first, .accumulator_second, .program_counter);

  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #20000;
    num_errors++;
    conclude();
  end
  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    rs = mm_rd;
    as = alu_valid;
    #1;
    if (rs) check(mm_rdata, rd_q.pop_front());
    if (as) check(alu_result, alu_q.pop_front());
    if (ea_strobe) begin
      e = ea_q.pop_front();
      check(operand_first, e[15:0]);
      check(operand_second, e[48:33]);
      check({15'h0000, operand_in_mem}, {15'h0000, e[32]});
      if (e[32]) check(effective_address, e[31:16]);
    end
  end
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic step();
    @(posedge ref_clk);
    {mm_wr, mm_rd, alu_valid, ea_valid} <= 4'h0;
  endtask
  task automatic mm(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    {mm_wr, mm_rd, alu_valid, ea_valid} <= {wr, !wr, 2'h0};
    mm_addr <= a;
    mm_wdata <= d;
    if (!wr) rd_q.push_back(d);
  endtask
  task automatic alu_rand();
    logic [15:0] a, b, bb, r;
    logic [16:0] s;
    logic [9:0]  k;
    logic [3:0]  ws;
    logic        ci;
    a = 16'($urandom);
    k = 10'($urandom);
    ws = 4'($urandom);
    b = k[8] ? a : 16'($urandom);
    bb = k[0] ? ~b : b;
    ci = k[1] ? fl[0] : k[0];
    s = {1'b0, a} + {1'b0, bb} + 17'(ci);
    r = s[15:0];
    if (k[2]) fl[0] = s[16];
    if (k[3]) fl[1] = (r == 16'h0000) && (!k[6] || fl[1]);
    if (k[4]) fl[2] = (a[15] == bb[15]) && (r[15] != a[15]);
    if (k[5]) fl[3] = r[15];
    if (k[7]) wm[k[9] ? 4'h0 : ws] = r;
    @(posedge ref_clk);
    {mm_wr, mm_rd, alu_valid, ea_valid} <= 4'h2;
    alu_op_a <= a;
    alu_op_b <= b;
    {alu_use_carry, alu_subtract} <= k[1:0];
    {wb_to_w, zero_sticky, upd_n, upd_ov, upd_z, upd_c} <= k[7:2];
    wb_default <= k[9];
    wb_sel <= ws;
    alu_q.push_back(r);
  endtask
  task automatic ea_rand(input int m);
    logic [31:0] k;
    logic [15:0] p, x, md, ma, o;
    k = $urandom;
    md = 16'($urandom);
    ma = 16'($urandom);
    p = wm[2];
    case (m)
      0: o = wm[0];
      1: o = p;
      7: o = k[24] ? {6'h00, k[9:0]} : {11'h000, k[4:0]};
      default: o = 16'h0000;
    endcase
    case (m)
      0: x = k[23] ? ma : {3'h0, k[22:10]};
      2: x = p;
      3: begin x = p; wm[2] = p + md; end
      4: begin x = p + md; wm[2] = x; end
      5: x = p + wm[5];
      6: x = p + {{6{k[9]}}, k[9:0]};
      default: x = 16'h0000;
    endcase
    @(posedge ref_clk);
    {mm_wr, mm_rd, alu_valid, ea_valid} <= 4'h1;
    ea_mode <= cpu_status_pkg::ea_mode_t'(8'h01 << m);
    {file_move, file_addr, literal} <= k[23:0];
    lit_wide <= k[24];
    mod_amount <= md;
    move_addr <= ma;
    ea_q.push_back({o, m != 1 && m != 7, x, wm[5]});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h6A7A50DC));
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    mm(0, 16'h0034, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      wm[i] = 16'($urandom);
      mm(1, 16'(2 * i), wm[i]);
    end
    for (int i = 0; i < 40; i++) begin
      alu_rand();
      mm(0, 16'h0034, {12'h000, fl});
    end
    for (int i = 0; i < 16; i++) mm(0, 16'(2 * i), wm[i]);
    for (int i = 0; i < 24; i++) ea_rand(i % 8);
    mm(0, 16'h0004, wm[2]);
    mm(1, 16'h0034, 16'h00E0);
    mm(0, 16'h0034, 16'h00E0);
    step();
    nesting_disable <= 1;
    core_priority_high <= 1;
    mm(1, 16'h0034, 16'h0040);
    mm(0, 16'h0034, 16'h00E0);
    step();
    nesting_disable <= 0;
    mm(1, 16'h0034, 16'h0040);
    mm(0, 16'h0034, 16'h0040);
    step();
    core_priority_high <= 0;
    mm(1, 16'h0034, 16'hE000);
    mm(0, 16'h0034, 16'hE000);
    mm(1, 16'h0034, 16'hC000);
    mm(0, 16'h0034, 16'h0000);
    step();
    sat_b_event <= 1;
    step();
    sat_b_event <= 0;
    repeat_running <= 1;
    mm(0, 16'h0034, 16'h6010);
    step();
    repeat_running <= 0;
    sat_a_event <= 1;
    step();
    sat_a_event <= 0;
    mm(1, 16'h0034, 16'h0010);
    mm(0, 16'h0034, 16'h0000);
    step();
    lstart_load <= 1;
    lstart_value <= 24'hA5C3E1;
    pc_load <= 1;
    pc_value <= 23'h3A1234;
    acc_wr <= 1;
    acc_wsel <= 1;
    acc_wdata <= 40'hC387654321;
    step();
    {lstart_load, pc_load, acc_wr} <= 3'h0;
    #1;
    check(program_counter[15:0], 16'h1234);
    check({9'h000, program_counter[22:16]}, 16'h003A);
    check(accumulator_second[15:0], 16'h4321);
    check(accumulator_second[39:24], 16'hC387);
    mm(1, 16'h0030, 16'h1234);
    mm(0, 16'h0030, 16'hC3E1);
    mm(0, 16'h0032, 16'h00A5);
    mm(0, 16'h002E, 16'h003A);
    mm(0, 16'h002A, 16'h00C3);
    mm(1, 16'h0020, 16'hBEEF);
    mm(0, 16'h0020, 16'hBEEF);
    mm(1, 16'h0040, 16'h1111);
    mm(0, 16'h0040, 16'h0000);
    step();
    ctx_sel <= 2;
    #1;
    check(accumulator_first[15:0], 16'hBEEF);
    mm(1, 16'h0006, 16'h2222);
    mm(1, 16'h001E, 16'h5555);
    step();
    ctx_sel <= 0;
    mm(0, 16'h0006, wm[3]);
    mm(0, 16'h001E, 16'h5555);
    step();
    ctx_sel <= 2;
    mm(0, 16'h0006, 16'h2222);
    step();
    step();
    conclude();
  end
endmodule
